// ==== src/apf_defs.svh ====
// Register offsets, field positions, reset values and sizes for the
// ancillary packet FIFO controller. Included by the design only.
`ifndef APF_DEFS_SVH
`define APF_DEFS_SVH

// Register offsets on the command port
`define APF_REG_CTRL0 7'h04
`define APF_REG_DID_VAL 7'h05
`define APF_REG_SDID_VAL 7'h06
`define APF_REG_DID_MASK 7'h07
`define APF_REG_SDID_MASK 7'h08
`define APF_REG_MSG 7'h17
`define APF_REG_PARITY 7'h18

// Control register 0 fields
`define APF_C0_DEPTH_HI 7
`define APF_C0_DEPTH_LO 5
`define APF_C0_FORCE 4
`define APF_C0_SUPPLIED 3
`define APF_C0_MISMATCH 1
`define APF_C0_OVERRUN 0

// Message control register fields
`define APF_MC_INS_EN 7
`define APF_MC_TRACK 6
`define APF_MC_DYN_WHOLE 5
`define APF_MC_STAT_WHOLE 4
`define APF_MC_DYN_OLD 3
`define APF_MC_STAT_OLD 2
`define APF_MC_FULL_REQ 1

// Parity and status register fields
`define APF_PS_EMPTY 7
`define APF_PS_FULL 6
`define APF_PS_PAR_DIS 0

// Reset values
`define APF_RST_MATCH 8'h00
`define APF_RST_MASK 8'hFF

// FIFO sizes
`define APF_DEPTH 7'h40
`define APF_MSG_MAX 4'h8
`define APF_VID_STAGES 4

`endif

// ==== src/apf_pkg.sv ====
// Types shared by the ancillary packet FIFO controller.
// Assumes apf_defs.svh supplies the numeric constants.
package apf_pkg;
  typedef logic [9:0] apf_word_t;
  typedef logic [6:0] apf_ptr_t;
  typedef enum logic [3:0] {
    apf_ld_idle = 4'b0001,
    apf_ld_body = 4'b0010,
    apf_ld_skip = 4'b0100,
    apf_ld_csum = 4'b1000
  } apf_load_t;
endpackage

// ==== src/apf_anc_fifo_ctrl.sv ====
// Ancillary packet FIFO control with packet admission, checksum handling,
// message tracking, flushing, insertion handshake and video delay line.
// Assumes host port and packet input run on aclk; serial side on clk.
//
// Behaviour
// - Video delay line depth is a 3-bit code, zero to four stages.
// - Writing into a full FIFO raises the overrun flag.
// - Either dynamic flush bit set disables the overrun flag.
// - Reading control register 0 clears an active, non-overridden overrun.
// - Checksum mismatch with replace enabled stores the computed checksum.
// - Checksum mismatch with replace disabled sets the mismatch flag.
// - Supplied-checksum mode checks received sums; otherwise device appends.
// - Identifier bits compare to match value except where mask bit set.
// - Low value and mask apply to DID, high ones to SDID/DBN.
// - Stored data goes to the stream only while insert is enabled.
// - Tracking keeps eight packets and checks length against free space.
// - Dynamic flushes work only with tracking enabled.
// - Dynamic whole flush on full drops older packets, keeps current.
// - Without dynamic whole flush a full FIFO overruns; dynamic bits stick.
// - Static whole flush empties FIFO, blocks loading, clears itself.
// - Dynamic oldest flush drops oldest packet when a new one loads.
// - Static oldest flush drops oldest packet while idle, then clears.
// - Complete-packet mode inserts only finished packets, tracking or not.
// - Otherwise partial packets up to the whole buffer may be inserted.
// - Unless disabled, DID/SDID parity errors stop a packet loading.
`timescale 1ns/1ps
`include "apf_defs.svh"

module apf_anc_fifo_ctrl (
  // Ancillary clock domain
  input wire logic aclk,
  input wire logic nrst,
  // Host command port
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  output logic cmd_rvalid,
  // Ancillary packet input
  input wire logic anc_valid,
  input wire apf_pkg::apf_word_t anc_data,
  input wire logic anc_eop,
  output logic anc_ready,
  // Status pins
  output logic fifo_empty,
  output logic fifo_full,
  output logic fifo_overrun,
  output logic checksum_mismatch_flag,
  // Serial clock domain
  input wire logic clk,
  input wire logic ins_slot,
  output logic ins_valid,
  output apf_pkg::apf_word_t ins_data,
  // Video path
  input wire logic [19:0] vid_in,
  output logic [19:0] vid_out
);
  import apf_pkg::*;

  function automatic apf_word_t apf_cs(input logic [8:0] s);
    return {~s[8], s};
  endfunction

  // Registers
  logic [2:0] vdepth_q;
  logic checksum_replace_enable_q, checksum_supplied_in_input_q;
  logic [7:0] did_val_q, sdid_val_q, did_mask_q, sdid_mask_q;
  logic ins_en_q, message_tracking_enable_q, dynamic_whole_flush_q;
  logic sflush_q, dynamic_oldest_packet_flush_q;
  logic static_oldest_packet_flush_q, complete_packet_required_q;
  logic identifier_parity_check_disable_q;
  logic ovr_q, mis_q, empty_q, full_q, ready_q;
  logic [7:0] rdata_q;
  logic rvalid_q;

  // FIFO state
  apf_word_t mem [0:63];
  apf_ptr_t wr_q, rd_q, commit_q, start_q;
  apf_ptr_t wr_d, rd_d, commit_d, start_d;
  apf_ptr_t mend [0:7];
  logic [2:0] head_q, tail_q, head_d, tail_d;
  logic [3:0] cnt_q, cnt_d;
  apf_load_t ld_q, ld_d;
  logic [7:0] wcnt_q;
  logic [8:0] sum_q, sum_d;

  // Comb results
  logic take, par_ok, did_hit, sdid_hit, we, rewind, pkt_done, new_pkt;
  logic mis_set, ovr_set, do_old, dwhole, space_short, full_eff, wrote;
  logic override, trk, avail, pop, req_edge, blocked, dec, inc;
  logic sflush_next, sold_next, c0_read, mc_wr;
  apf_word_t wdat;
  apf_ptr_t used, cur_start;

  assign trk = message_tracking_enable_q;
  assign override = dynamic_whole_flush_q | dynamic_oldest_packet_flush_q;
  assign take = anc_valid & ready_q;
  assign c0_read = cmd_rd & (cmd_addr == `APF_REG_CTRL0);
  assign mc_wr = cmd_wr & (cmd_addr == `APF_REG_MSG);
  assign used = 7'(wr_q - rd_q);

  // Parity and identifier admission
  always_comb begin
    par_ok = identifier_parity_check_disable_q |
             ((anc_data[8] == ^anc_data[7:0]) &
              (anc_data[9] != anc_data[8]));
    did_hit = par_ok &
      (((anc_data[7:0] ^ did_val_q) & ~did_mask_q) == 8'h00);
    sdid_hit = par_ok &
      (((anc_data[7:0] ^ sdid_val_q) & ~sdid_mask_q) == 8'h00);
  end

  // Packet load sequencer and checksum handling
  always_comb begin
    ld_d = ld_q;
    we = 1'b0;
    wdat = anc_data;
    rewind = 1'b0;
    pkt_done = 1'b0;
    new_pkt = 1'b0;
    mis_set = 1'b0;
    sum_d = sum_q;
    unique case (ld_q)
      apf_ld_idle: begin
        if (take) begin
          if (did_hit) begin
            we = 1'b1;
            new_pkt = 1'b1;
            sum_d = anc_data[8:0];
            ld_d = apf_ld_body;
          end else begin
            ld_d = anc_eop ? apf_ld_idle : apf_ld_skip;
          end
        end
      end
      apf_ld_body: begin
        if (take) begin
          if (wcnt_q == 8'h01 && !sdid_hit) begin
            rewind = 1'b1;
            ld_d = anc_eop ? apf_ld_idle : apf_ld_skip;
          end else if (anc_eop && checksum_supplied_in_input_q) begin
            we = 1'b1;
            pkt_done = 1'b1;
            ld_d = apf_ld_idle;
            if (anc_data != apf_cs(sum_q)) begin
              if (checksum_replace_enable_q) begin
                wdat = apf_cs(sum_q);
              end else begin
                mis_set = 1'b1;
              end
            end
          end else begin
            we = 1'b1;
            sum_d = 9'(sum_q + anc_data[8:0]);
            if (anc_eop) begin
              ld_d = apf_ld_csum;
            end
          end
        end
      end
      apf_ld_skip: begin
        if (take && anc_eop) begin
          ld_d = apf_ld_idle;
        end
      end
      apf_ld_csum: begin
        we = 1'b1;
        wdat = apf_cs(sum_q);
        pkt_done = 1'b1;
        ld_d = apf_ld_idle;
      end
    endcase
    if (sflush_q) begin
      ld_d = apf_ld_idle;
      we = 1'b0;
      pkt_done = 1'b0;
    end
  end

  // Flush decisions
  always_comb begin
    cur_start = new_pkt ? wr_q : start_q;
    space_short = trk & (ld_q == apf_ld_body) & take & (wcnt_q == 8'h02) &
      (({1'b0, anc_data[7:0]} + 9'h002) >
       {2'b00, 7'(`APF_DEPTH - used)});
    dwhole = trk & dynamic_whole_flush_q & ~sflush_q &
      ((we & (used == `APF_DEPTH)) | space_short);
    do_old = ~sflush_q & (cnt_q != 4'h0) &
      ((trk & dynamic_oldest_packet_flush_q & new_pkt) |
       (static_oldest_packet_flush_q & (ld_q == apf_ld_idle) &
        ~anc_valid));
    full_eff = dwhole ? (7'(wr_q - cur_start) == `APF_DEPTH)
                      : (used == `APF_DEPTH);
    wrote = we & ~full_eff;
    ovr_set = we & full_eff & ~override;
    blocked = sflush_q | do_old | dwhole;
    avail = complete_packet_required_q ? (rd_q != commit_q)
                                       : (rd_q != wr_q);
    pop = req_edge & ins_en_q & avail & ~blocked;
  end

  // Next pointers and message records
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    commit_d = commit_q;
    start_d = new_pkt ? wr_q : start_q;
    head_d = head_q;
    tail_d = tail_q;
    dec = 1'b0;
    inc = 1'b0;
    if (sflush_q) begin
      rd_d = wr_q;
      commit_d = wr_q;
      head_d = tail_q;
    end else begin
      if (pop) begin
        rd_d = 7'(rd_q + 7'h01);
        dec = (cnt_q != 4'h0) && (rd_d == mend[head_q]);
      end
      if (do_old) begin
        rd_d = mend[head_q];
        dec = 1'b1;
      end
      if (dec) begin
        head_d = 3'(head_q + 3'h1);
      end
      if (dwhole) begin
        rd_d = cur_start;
        commit_d = cur_start;
        head_d = tail_q;
      end
      if (wrote) begin
        wr_d = 7'(wr_q + 7'h01);
      end
      if (rewind) begin
        wr_d = start_q;
      end
      if (pkt_done) begin
        commit_d = wr_d;
        inc = trk & (wrote | (wr_q != start_q)) &
              ((dwhole ? 4'h0 : cnt_q) != `APF_MSG_MAX);
        if (inc) begin
          tail_d = 3'(tail_q + 3'h1);
        end
      end
    end
    cnt_d = (sflush_q | dwhole) ? 4'h0 : 4'(cnt_q - {3'h0, dec});
    cnt_d = 4'(cnt_d + {3'h0, inc});
  end

  // Self-clearing flush requests
  assign sflush_next = sflush_q ? 1'b0 : mc_wr & cmd_wdata[`APF_MC_STAT_WHOLE];
  assign sold_next = (static_oldest_packet_flush_q &
    ~((ld_q == apf_ld_idle) & ~anc_valid)) |
    (mc_wr & cmd_wdata[`APF_MC_STAT_OLD]);

  // FIFO storage and message end records
  always_ff @(posedge aclk) begin
    if (wrote) begin
      mem[wr_q[5:0]] <= wdat;
    end
    if (inc) begin
      mend[tail_q] <= wr_d;
    end
  end

  // Pointers, load state and flags
  always_ff @(posedge aclk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 7'h00;
      rd_q <= 7'h00;
      commit_q <= 7'h00;
      start_q <= 7'h00;
      head_q <= 3'h0;
      tail_q <= 3'h0;
      cnt_q <= 4'h0;
      ld_q <= apf_ld_idle;
      wcnt_q <= 8'h00;
      sum_q <= 9'h000;
      empty_q <= 1'b1;
      full_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      commit_q <= commit_d;
      start_q <= start_d;
      head_q <= head_d;
      tail_q <= tail_d;
      cnt_q <= cnt_d;
      ld_q <= ld_d;
      sum_q <= sum_d;
      if (take) begin
        wcnt_q <= (ld_q == apf_ld_idle) ? 8'h01
                : (wcnt_q == 8'hFF) ? wcnt_q : 8'(wcnt_q + 8'h01);
      end
      empty_q <= (wr_d == rd_d);
      full_q <= (7'(wr_d - rd_d) == `APF_DEPTH);
      ready_q <= (ld_d != apf_ld_csum) & ~sflush_next;
    end
  end

  // Host registers
  always_ff @(posedge aclk or negedge nrst) begin
    if (!nrst) begin
      vdepth_q <= 3'h0;
      checksum_replace_enable_q <= 1'b0;
      checksum_supplied_in_input_q <= 1'b0;
      did_val_q <= `APF_RST_MATCH;
      sdid_val_q <= `APF_RST_MATCH;
      did_mask_q <= `APF_RST_MASK;
      sdid_mask_q <= `APF_RST_MASK;
      ins_en_q <= 1'b0;
      message_tracking_enable_q <= 1'b0;
      dynamic_whole_flush_q <= 1'b0;
      sflush_q <= 1'b0;
      dynamic_oldest_packet_flush_q <= 1'b0;
      static_oldest_packet_flush_q <= 1'b0;
      complete_packet_required_q <= 1'b0;
      identifier_parity_check_disable_q <= 1'b0;
    end else begin
      sflush_q <= sflush_next;
      static_oldest_packet_flush_q <= sold_next;
      if (cmd_wr) begin
        unique case (cmd_addr)
          `APF_REG_CTRL0: begin
            vdepth_q <= cmd_wdata[`APF_C0_DEPTH_HI:`APF_C0_DEPTH_LO];
            checksum_replace_enable_q <= cmd_wdata[`APF_C0_FORCE];
            checksum_supplied_in_input_q <= cmd_wdata[`APF_C0_SUPPLIED];
          end
          `APF_REG_DID_VAL: did_val_q <= cmd_wdata;
          `APF_REG_SDID_VAL: sdid_val_q <= cmd_wdata;
          `APF_REG_DID_MASK: did_mask_q <= cmd_wdata;
          `APF_REG_SDID_MASK: sdid_mask_q <= cmd_wdata;
          `APF_REG_MSG: begin
            ins_en_q <= cmd_wdata[`APF_MC_INS_EN];
            message_tracking_enable_q <= cmd_wdata[`APF_MC_TRACK];
            dynamic_whole_flush_q <= cmd_wdata[`APF_MC_DYN_WHOLE];
            dynamic_oldest_packet_flush_q <= cmd_wdata[`APF_MC_DYN_OLD];
            complete_packet_required_q <= cmd_wdata[`APF_MC_FULL_REQ];
          end
          `APF_REG_PARITY: begin
            identifier_parity_check_disable_q <= cmd_wdata[`APF_PS_PAR_DIS];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Sticky status flags; a new event beats the read clear
  always_ff @(posedge aclk or negedge nrst) begin
    if (!nrst) begin
      ovr_q <= 1'b0;
      mis_q <= 1'b0;
    end else begin
      if (ovr_set) begin
        ovr_q <= 1'b1;
      end else if (c0_read && !override) begin
        ovr_q <= 1'b0;
      end
      if (mis_set) begin
        mis_q <= 1'b1;
      end else if (c0_read) begin
        mis_q <= 1'b0;
      end
    end
  end

  // Register read-back, one cycle after the strobe
  always_ff @(posedge aclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cmd_rd;
      unique case (cmd_addr)
        `APF_REG_CTRL0: rdata_q <= {vdepth_q, checksum_replace_enable_q,
          checksum_supplied_in_input_q, 1'b0, mis_q, ovr_q};
        `APF_REG_DID_VAL: rdata_q <= did_val_q;
        `APF_REG_SDID_VAL: rdata_q <= sdid_val_q;
        `APF_REG_DID_MASK: rdata_q <= did_mask_q;
        `APF_REG_SDID_MASK: rdata_q <= sdid_mask_q;
        `APF_REG_MSG: rdata_q <= {ins_en_q, message_tracking_enable_q,
          dynamic_whole_flush_q, sflush_q, dynamic_oldest_packet_flush_q,
          static_oldest_packet_flush_q, complete_packet_required_q, 1'b0};
        `APF_REG_PARITY: rdata_q <= {empty_q, full_q, 5'h00,
          identifier_parity_check_disable_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // Insertion handshake: clk asks by toggle, aclk answers by toggle
  logic req_tgl_q, ack_tgl_q, busy_q, ins_valid_q;
  logic req_s1_q, req_s2_q, req_s3_q, ack_s1_q, ack_s2_q, ack_s3_q;
  logic hit_q;
  apf_word_t out_q, ins_data_q;
  assign req_edge = req_s2_q ^ req_s3_q;

  // Aclk side: pop one word per request
  always_ff @(posedge aclk or negedge nrst) begin
    if (!nrst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      hit_q <= 1'b0;
      out_q <= 10'h000;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      if (req_edge) begin
        hit_q <= pop;
        out_q <= mem[rd_q[5:0]];
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

  // Clk side: request per slot, present word when answer arrives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_tgl_q <= 1'b0;
      busy_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      ins_valid_q <= 1'b0;
      ins_data_q <= 10'h000;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      ins_valid_q <= (ack_s2_q ^ ack_s3_q) & hit_q;
      if (ack_s2_q ^ ack_s3_q) begin
        ins_data_q <= out_q;
        busy_q <= 1'b0;
      end else if (ins_slot && !busy_q) begin
        req_tgl_q <= ~req_tgl_q;
        busy_q <= 1'b1;
      end
    end
  end

  // Video alignment delay line
  logic [2:0] dep_s1_q, dep_s2_q, dep_s3_q, dep_q;
  logic [19:0] vpipe_q [0:`APF_VID_STAGES-1];
  logic [19:0] vid_q;
  genvar gi;
  generate
    for (gi = 0; gi < `APF_VID_STAGES; gi++) begin : g_vstage
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          vpipe_q[gi] <= 20'h0_0000;
        end else begin
          vpipe_q[gi] <= (gi == 0) ? vid_in : vpipe_q[(gi == 0) ? 0 : gi-1];
        end
      end
    end
  endgenerate

  // Depth select; codes above four hold four stages
  // Code is a multi-bit aclk word: taken only when two synced samples agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dep_s1_q <= 3'h0;
      dep_s2_q <= 3'h0;
      dep_s3_q <= 3'h0;
      dep_q <= 3'h0;
      vid_q <= 20'h0_0000;
    end else begin
      dep_s1_q <= vdepth_q;
      dep_s2_q <= dep_s1_q;
      dep_s3_q <= dep_s2_q;
      if (dep_s2_q == dep_s3_q) begin
        dep_q <= dep_s2_q;
      end
      if (dep_q == 3'h0) begin
        vid_q <= vid_in;
      end else if (dep_q > 3'h4) begin
        vid_q <= vpipe_q[3];
      end else begin
        vid_q <= vpipe_q[dep_q[1:0] - 2'h1];
      end
    end
  end

  // Outputs
  assign cmd_rdata = rdata_q;
  assign cmd_rvalid = rvalid_q;
  assign anc_ready = ready_q;
  assign fifo_empty = empty_q;
  assign fifo_full = full_q;
  assign fifo_overrun = ovr_q;
  assign checksum_mismatch_flag = mis_q;
  assign ins_valid = ins_valid_q;
  assign ins_data = ins_data_q;
  assign vid_out = vid_q;

  // Checks
  a_flags_match: assert property (@(posedge aclk)
    disable iff (!nrst)
    empty_q == (wr_q == rd_q) && full_q == (used == `APF_DEPTH))
    else $error("empty/full flags disagree with occupancy");
  a_ovr_full: assert property (@(posedge aclk)
    disable iff (!nrst)
    (ld_q == apf_ld_csum && full_q && !override && !sflush_q &&
     !message_tracking_enable_q) |=> ovr_q)
    else $error("overrun not raised on write into full FIFO");
  a_ovr_override: assert property (@(posedge aclk)
    disable iff (!nrst) (override && !ovr_q) |=> !ovr_q)
    else $error("overrun set while overridden");
  a_ovr_rdclr: assert property (@(posedge aclk)
    disable iff (!nrst) (c0_read && !override && !ovr_set) |=> !ovr_q)
    else $error("overrun not cleared by status read");
  a_mis_flag: assert property (@(posedge aclk)
    disable iff (!nrst)
    (ld_q == apf_ld_body && take && anc_eop && wcnt_q != 8'h01 &&
     checksum_supplied_in_input_q && !checksum_replace_enable_q &&
     !sflush_q && anc_data != apf_cs(sum_q)) |=> mis_q)
    else $error("checksum mismatch not flagged");
  a_did_reject: assert property (@(posedge aclk)
    disable iff (!nrst)
    (ld_q == apf_ld_idle && take && !did_hit) |=> $stable(wr_q))
    else $error("rejected identifier was stored");
  a_sflush_done: assert property (@(posedge aclk)
    disable iff (!nrst) sflush_q |-> !ready_q ##1 (!sflush_q && empty_q))
    else $error("static flush did not empty and clear");
  a_ins_gate: assert property (@(posedge aclk)
    disable iff (!nrst) $rose(hit_q) |-> $past(ins_en_q))
    else $error("word inserted while insertion disabled");
  a_full_msg: assert property (@(posedge aclk)
    disable iff (!nrst)
    (pop && complete_packet_required_q) |-> rd_q != commit_q)
    else $error("partial packet popped in complete-packet mode");
  a_vid_depth: assert property (@(posedge clk)
    disable iff (!nrst)
    (dep_q == 3'h2 && $past(dep_q, 3) == 3'h2) |->
    vid_q == $past(vid_in, 3))
    else $error("video delay differs from two stages");

endmodule

// ==== test/apf_host_model.sv ====
// Host-side source of ancillary packets for the packet input.
// Assumes words are offered on aclk and taken when anc_ready is high.
`timescale 1ns/1ps
module apf_host_model (
  // Ancillary clock and handshake
  input wire logic aclk,
  input wire logic anc_ready,
  // Packet words towards the device
  output apf_pkg::apf_word_t anc_data,
  output logic anc_valid,
  output logic anc_eop
);
  import apf_pkg::*;
  // Idle lines at time zero
  initial begin
    anc_valid = 1'b0;
    anc_eop = 1'b0;
    anc_data = 10'h000;
  end
  // Offer each word and hold it until the edge that takes it
  task automatic send(input apf_word_t w[$]);
    @(posedge aclk);
    foreach (w[i]) begin
      anc_valid <= 1'b1;
      anc_data <= w[i];
      anc_eop <= (i == w.size() - 1);
      do @(posedge aclk); while (anc_ready !== 1'b1);
    end
    // Released data lines show the inverse of the last word
    anc_valid <= 1'b0;
    anc_eop <= 1'b0;
    anc_data <= ~w[w.size() - 1];
  endtask
endmodule

// ==== test/apf_anc_fifo_ctrl_test.sv ====
// Self-checking bench for the ancillary packet FIFO controller.
// Assumes apf_pkg is compiled first; aclk 48 ns, clk 4 ns.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin \
  error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module apf_anc_fifo_ctrl_test;
  import apf_pkg::*;
  logic aclk, clk, nrst, cmd_wr, cmd_rd, cmd_rvalid, anc_valid, anc_eop;
  logic anc_ready, fifo_empty, fifo_full, fifo_overrun, ins_slot, ins_valid;
  logic checksum_mismatch_flag;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_wdata, cmd_rdata, r;
  logic [19:0] vid_in, vid_out;
  apf_word_t anc_data, ins_data, w;
  apf_word_t tx[$], px[$], ex[$];
  bit g;
  int error_cnt = 0, checked = 0;
  logic [6:0] ra [6] = '{7'h05, 7'h06, 7'h07, 7'h08, 7'h18, 7'h7F};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h80, 8'h00};

  apf_anc_fifo_ctrl u_apf_anc_fifo_ctrl (.aclk, .nrst, .cmd_wr, .cmd_rd,
    .cmd_addr, .cmd_wdata, .cmd_rdata, .cmd_rvalid, .anc_valid, .anc_data,
    .anc_eop, .anc_ready, .fifo_empty, .fifo_full, .fifo_overrun,
    .checksum_mismatch_flag, .clk, .ins_slot, .ins_valid, .ins_data,
    .vid_in, .vid_out);
  apf_host_model u_apf_host_model (.aclk, .anc_ready, .anc_data,
    .anc_valid, .anc_eop);

  // Serial clock and free-running ancillary clock of unrelated phase
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    aclk = 1'b0;
    #7;
    forever #24 aclk = ~aclk;
  end
  // Video input counts up so the delay shows as a difference
  always @(posedge clk) vid_in <= vid_in + 20'h0_0001;

  function automatic apf_word_t wd(input logic [7:0] v);
    return {~(^v), ^v, v};
  endfunction
  // Build one packet: words sent and words expected in storage
  task automatic pk(input logic [7:0] d, s, input int n, input bit sup,
                    input bit bad, input bit bp);
    logic [8:0] c;
    c = '0;
    tx = {};
    for (int i = 0; i < n + 3; i++) begin
      w = wd(i == 0 ? d : i == 1 ? s : i == 2 ? 8'(n) : 8'(8'h10 + i));
      if (i == 0 && bp) w[8] = ~w[8];
      tx.push_back(w);
      c += w[8:0];
    end
    px = tx;
    px.push_back({~c[8], c});
    if (sup) tx.push_back(bad ? {~c[8], c} ^ 10'h001 : {~c[8], c});
  endtask
  task automatic snd();
    u_apf_host_model.send(tx);
    repeat (4) @(posedge aclk);
  endtask
  // Register port write and read
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge aclk);
    cmd_wr <= 1'b1;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge aclk);
    cmd_wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge aclk);
    cmd_rd <= 1'b1;
    cmd_addr <= a;
    @(posedge aclk);
    cmd_rd <= 1'b0;
    @(posedge aclk);
    d = cmd_rdata;
    `CHK("cmd_rvalid", 1'b1, cmd_rvalid)
  endtask
  // One insertion request; waits longer than the worst answer time
  task automatic ig(output apf_word_t q, output bit got);
    got = 1'b0;
    q = '0;
    @(posedge clk) ins_slot <= 1'b1;
    @(posedge clk) ins_slot <= 1'b0;
    for (int k = 0; k < 80 && !got; k++) begin
      @(posedge clk);
      if (ins_valid === 1'b1) begin
        got = 1'b1;
        q = ins_data;
      end
    end
  endtask
  // Drain every expected word, then the FIFO must read empty
  task automatic drn();
    foreach (ex[i]) begin
      ig(w, g);
      `CHK("ins_data", ex[i], w)
    end
    `CHK("fifo_empty", 1'b1, fifo_empty)
    ex = {};
  endtask
  task print_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    {cmd_wr, cmd_rd, ins_slot, cmd_addr, cmd_wdata, vid_in} = '0;
    repeat (5) @(posedge aclk);
    nrst <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], r);
      `CHK("reg", rv[i], r)
    end
    for (int d = 0; d < 5; d++) begin
      wr(7'h04, 8'(d << 5));
      repeat (20) @(negedge clk);
      `CHK("vid_out", vid_in - 20'(d + 1), vid_out)
    end
    // Exact identifier match, then one masked DID bit
    wr(7'h05, 8'h61);
    wr(7'h06, 8'h02);
    wr(7'h07, 8'h00);
    wr(7'h08, 8'h00);
    pk(8'h60, 8'h02, 2, 0, 0, 0);
    snd();
    `CHK("fifo_empty", 1'b1, fifo_empty)
    pk(8'h61, 8'h03, 2, 0, 0, 0);
    snd();
    `CHK("fifo_empty", 1'b1, fifo_empty)
    pk(8'h61, 8'h02, 2, 0, 0, 0);
    snd();
    ex = px;
    wr(7'h07, 8'h01);
    pk(8'h60, 8'h02, 1, 0, 0, 0);
    snd();
    ex = {ex, px};
    ig(w, g);
    `CHK("ins_valid", 1'b0, g)
    wr(7'h17, 8'h80);
    drn();
    // Parity error refused until checking is disabled
    pk(8'h61, 8'h02, 1, 0, 0, 1);
    snd();
    `CHK("fifo_empty", 1'b1, fifo_empty)
    wr(7'h18, 8'h01);
    snd();
    ex = px;
    drn();
    // Supplied checksum: mismatch flagged, cleared by read
    wr(7'h04, 8'h08);
    pk(8'h61, 8'h02, 3, 1, 1, 0);
    snd();
    `CHK("csum_flag", 1'b1, checksum_mismatch_flag)
    rd(7'h04, r);
    `CHK("reg04", 8'h0A, r)
    wr(7'h17, 8'h90);
    @(negedge aclk);
    `CHK("anc_ready", 1'b0, anc_ready)
    rd(7'h17, r);
    `CHK("reg17", 8'h80, r)
    `CHK("fifo_empty", 1'b1, fifo_empty)
    wr(7'h04, 8'h18);
    snd();
    `CHK("csum_flag", 1'b0, checksum_mismatch_flag)
    ex = px;
    drn();
    // Fill to full, overrun, clear by reading
    wr(7'h04, 8'h00);
    wr(7'h07, 8'hFF);
    wr(7'h08, 8'hFF);
    wr(7'h17, 8'h00);
    pk(8'h41, 8'h01, 12, 0, 0, 0);
    repeat (4) snd();
    `CHK("fifo_full", 1'b1, fifo_full)
    // Dynamic bit without tracking: no flush, overrun still overridden
    wr(7'h17, 8'h20);
    snd();
    `CHK("overrun", 1'b0, fifo_overrun)
    `CHK("fifo_full", 1'b1, fifo_full)
    wr(7'h17, 8'h00);
    snd();
    `CHK("overrun", 1'b1, fifo_overrun)
    rd(7'h04, r);
    `CHK("reg04", 8'h01, r)
    `CHK("overrun", 1'b0, fifo_overrun)
    // Dynamic whole flush keeps only the packet being loaded
    wr(7'h17, 8'h60);
    pk(8'h42, 8'h01, 4, 0, 0, 0);
    snd();
    `CHK("overrun", 1'b0, fifo_overrun)
    rd(7'h17, r);
    `CHK("reg17", 8'h60, r)
    wr(7'h17, 8'hE0);
    ex = px;
    drn();
    // Static oldest flush, then dynamic oldest flush
    wr(7'h17, 8'h40);
    pk(8'h43, 8'h01, 2, 0, 0, 0);
    snd();
    pk(8'h44, 8'h01, 2, 0, 0, 0);
    snd();
    ex = px;
    wr(7'h17, 8'h44);
    rd(7'h17, r);
    `CHK("reg17", 8'h40, r)
    wr(7'h17, 8'hC0);
    drn();
    wr(7'h17, 8'h48);
    pk(8'h45, 8'h01, 2, 0, 0, 0);
    snd();
    pk(8'h46, 8'h01, 2, 0, 0, 0);
    snd();
    ex = px;
    wr(7'h17, 8'hC8);
    drn();
    // Slot during loading: held back only in complete-packet mode
    pk(8'h47, 8'h01, 12, 0, 0, 0);
    for (int m = 0; m < 2; m++) begin
      wr(7'h17, m ? 8'h80 : 8'h82);
      fork
        snd();
        ig(w, g);
      join
      `CHK("ins_valid", 1'(m), g)
      ex = px;
      if (m) begin
        `CHK("ins_data", px[0], w)
        ex.delete(0);
      end
      drn();
    end
    print_verdict();
  end
  // Watchdog well beyond the expected run time
  initial begin
    #300_000;
    error_cnt++;
    print_verdict();
  end
endmodule
